// File: rtl/bss_params.svh
/*
 * Constants of the startup sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 125 MHz pclk; included by bare name from the rtl files.
 */
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

// register byte offsets on the apb bus
`define BSS_CTRL_OFS      12'h000
`define BSS_SETUP_OFS     12'h004
`define BSS_SPEED_OFS     12'h008
`define BSS_STATUS_OFS    12'h00C
`define BSS_PERIOD_OFS    12'h010

// field positions
`define BSS_CTRL_DIR_BIT  0
`define BSS_SETUP_FST_LSB 0
`define BSS_SETUP_VST_LSB 8
`define BSS_STAT_HALL_BIT 3
`define BSS_STAT_DIR_BIT  4
`define BSS_STAT_FST_LSB  5
`define BSS_STAT_STEP_LSB 8

// reset values
`define BSS_CTRL_RST      1'h0
`define BSS_SETUP_RST     16'h0000
`define BSS_SPEED_RST     8'h00

// setting-voltage code thresholds for the rate step decode
`define BSS_FST_STEP2_MIN 8'h78
`define BSS_FST_STEP1_MIN 8'h28

// timing
`define BSS_CLK_HZ        125000000
`define BSS_CLK_PERIOD_NS 8
`define BSS_EXC_UNIT_NS   3130000
`define BSS_EXC_UNITS     32
`define BSS_DETECT_NS     50000000
`define BSS_F40_DHZ       400
`define BSS_F200_DHZ      2000
`define BSS_FST2_DHZ      16
`define BSS_FST1_DHZ      64
`define BSS_FST0_DHZ      32
`define BSS_EXC_UNIT_CYC  ((`BSS_EXC_UNIT_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)
`define BSS_DETECT_CYC    ((`BSS_DETECT_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)
`define BSS_DHZ_CYC(f)    ((`BSS_CLK_HZ * 10) / (f))

`endif

// File: rtl/bss_pkg.sv
/*
 * Types of the startup sequencer: state codes and per-phase drive codes.
 * Assumes nothing of its surroundings.
 */
package bss_pkg;

	typedef enum logic [2:0] {
		bss_st_idle   = 3'b000,
		bss_st_detect = 3'b001,
		bss_st_rbrake = 3'b010,
		bss_st_sbrake = 3'b011,
		bss_st_exc1   = 3'b100,
		bss_st_exc2   = 3'b101,
		bss_st_forced = 3'b110,
		bss_st_pwm    = 3'b111
	} bss_state_t;

	typedef enum logic [2:0] {
		bss_ph_off     = 3'b000,
		bss_ph_hi_full = 3'b001,
		bss_ph_lo_full = 3'b010,
		bss_ph_hi_pwm  = 3'b011,
		bss_ph_lo_pwm  = 3'b100
	} bss_phase_t;

endpackage : bss_pkg

// File: rtl/bss_sync.sv
/*
 * Three-stage synchroniser for pin inputs, one chain per bit.
 * Assumes inputs asynchronous to pclk; output moves when stages two and three agree.
 */
`timescale 1ns/100ps
`default_nettype none

module bss_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;

		// first stage feeds only the second; agreement filters a late settle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1_q        <= 1'b0;
				s2_q        <= 1'b0;
				s3_q        <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				s1_q <= async_in[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					sync_out[i] <= s3_q;
				end
			end
		end
	end

endmodule : bss_sync

`default_nettype wire

// File: rtl/bss_period_meter.sv
/*
 * Position-signal period meter: counts pclk cycles between rising edges of
 * the hall state and flags each edge.
 * Assumes a level already on pclk; counter saturates when the rotor stands.
 */
`timescale 1ns/100ps
`default_nettype none

module bss_period_meter #(
	parameter int CNT_W = 27
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             level_in,
	output logic                  rise_pulse,
	output logic                  edge_pulse,
	output logic      [CNT_W-1:0] period,
	output logic      [CNT_W-1:0] live_period
);

	logic             level_q;
	logic [CNT_W-1:0] cnt_q;
	logic             rise;

	assign rise = level_in & ~level_q;

	// a stopped rotor must read as slow, so the running count wins once it is longer
	assign live_period = (cnt_q > period) ? cnt_q : period;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q    <= 1'b0;
			rise_pulse <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			level_q    <= level_in;
			rise_pulse <= rise;
			edge_pulse <= level_in ^ level_q;
		end
	end

	// period counter, latched and restarted on each rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= {CNT_W{1'b1}};
			period <= {CNT_W{1'b1}};
		end else if (rise) begin
			period <= cnt_q;
			cnt_q  <= {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (cnt_q != {CNT_W{1'b1}}) begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule : bss_period_meter

`default_nettype wire

// File: rtl/bss_startup_seq.sv
/*
 * Startup sequencer of a three-phase single-hall brushless motor driver:
 * apb register slave, direction/speed detection, brake, dc excitation,
 * forced commutation and pwm drive with per-phase gate outputs.
 * Assumes one 125 MHz clock, hall and sense pins asynchronous to it,
 * and an external gate stage that inserts dead time.
 */
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bss_params.svh"

// Operation
// - On a start command detect direction and speed, and go straight to pwm drive if direction is known and matches.
// - A known but opposite direction leads to reverse brake, then forced commutation, then pwm drive.
// - Unknown direction at 40 Hz or less leads to dc excitation, forced commutation, then pwm drive.
// - Unknown direction between 40 and 200 Hz adds a short brake before dc excitation.
// - Unknown direction above 200 Hz repeats the direction detection and starts no drive.
// - Forced commutation hands over to pwm drive once position frequency exceeds the selected rate.
// - In dc excitation and forced commutation the duty comes from the startup duty voltage.
// - In pwm drive the duty comes from the speed command, which also starts, changes and stops the motor.
// - Dc excitation is two equal intervals, stage one then stage two, then forced commutation.
// - Each excitation interval is 32 units of the timing base, about 0.100 s.
// - Forward and hall high, stage one drives U low full on, V off, W high-side pwm.
// - Forward and hall high, stage two drives U off, V low-side pwm, W high full on.
// - Direction select low means forward order U V W, high means reverse order W V U.
// - Rate setting step 2 is about 1.6 Hz, step 1 about 6.4 Hz, step 0 about 3.2 Hz.
// - Forward and hall low, stage one is U high full, V off, W low pwm; stage two U off, V high pwm, W low full.
module bss_startup_seq #(
	parameter int unsigned EXC_UNIT_CYC = `BSS_EXC_UNIT_CYC,
	parameter int unsigned DETECT_CYC   = `BSS_DETECT_CYC,
	parameter int unsigned P40_CYC      = `BSS_DHZ_CYC(`BSS_F40_DHZ),
	parameter int unsigned P200_CYC     = `BSS_DHZ_CYC(`BSS_F200_DHZ),
	parameter int unsigned FST2_CYC     = `BSS_DHZ_CYC(`BSS_FST2_DHZ),
	parameter int unsigned FST1_CYC     = `BSS_DHZ_CYC(`BSS_FST1_DHZ),
	parameter int unsigned FST0_CYC     = `BSS_DHZ_CYC(`BSS_FST0_DHZ)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hall_positive_input,
	input  wire logic        hall_negative_input,
	input  wire logic        rotation_sense,
	output logic      [2:0]  phase_high_q,
	output logic      [2:0]  phase_low_q
);

	localparam int TW = 27;
	localparam logic [TW-1:0] EXC_UNIT_T = TW'(EXC_UNIT_CYC);
	localparam logic [TW-1:0] DETECT_T   = TW'(DETECT_CYC);
	localparam logic [TW-1:0] P40_T      = TW'(P40_CYC);
	localparam logic [TW-1:0] P200_T     = TW'(P200_CYC);
	localparam logic [5:0]    UNITS_LAST = 6'(`BSS_EXC_UNITS - 1);

	bss_pkg::bss_state_t state_q;
	bss_pkg::bss_state_t state_d;

	logic          dir_sel_q;
	logic [15:0]   setup_q;
	logic [7:0]    speed_q;
	logic [2:0]    sync_s;
	logic          hall_q;
	logic          hall_rise;
	logic          hall_edge;
	logic [TW-1:0] period;
	logic [TW-1:0] live_period;
	logic [TW-1:0] timer_q;
	logic [5:0]    units_q;
	logic          dir_q;
	logic [1:0]    fst_step_q;
	logic [1:0]    fst_step;
	logic [TW-1:0] fst_t;
	logic          after_exc_q;
	logic [1:0]    det_edges_q;
	logic          det_mis_q;
	logic          det_dir_q;
	logic [2:0]    step_q;
	logic [1:0]    sub_q;
	logic [7:0]    pwm_cnt_q;
	logic [7:0]    duty;
	logic          pwm_on;
	logic          unit_tick;
	logic          fc_tick;
	logic          pwm_tick;
	logic          det_done;
	logic          det_ok;
	logic          in_exc;
	logic          apb_wr;
	logic [7:0]    fst_code;

	// ---------------- apb slave ----------------
	assign apb_wr = psel & penable & pready & pwrite;

	// one wait-free access cycle: answer is prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == `BSS_CTRL_OFS) begin
					prdata[`BSS_CTRL_DIR_BIT] <= dir_sel_q;
				end else if (paddr == `BSS_SETUP_OFS) begin
					prdata[15:0] <= setup_q;
				end else if (paddr == `BSS_SPEED_OFS) begin
					prdata[7:0] <= speed_q;
				end else if (paddr == `BSS_STATUS_OFS) begin
					prdata[2:0]                     <= state_q;
					prdata[`BSS_STAT_HALL_BIT]      <= hall_q;
					prdata[`BSS_STAT_DIR_BIT]       <= dir_q;
					prdata[`BSS_STAT_FST_LSB +: 2]  <= fst_step_q;
					prdata[`BSS_STAT_STEP_LSB +: 3] <= step_q;
				end else if (paddr == `BSS_PERIOD_OFS) begin
					prdata[TW-1:0] <= period;
				end else begin
					pslverr <= 1'b1; // unmapped: error, reads zero
				end
			end
		end
	end

	// software registers; writes land at the completing access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_sel_q <= `BSS_CTRL_RST;
			setup_q   <= `BSS_SETUP_RST;
			speed_q   <= `BSS_SPEED_RST;
		end else if (apb_wr) begin
			if (paddr == `BSS_CTRL_OFS) begin
				dir_sel_q <= pwdata[`BSS_CTRL_DIR_BIT];
			end else if (paddr == `BSS_SETUP_OFS) begin
				setup_q <= pwdata[15:0];
			end else if (paddr == `BSS_SPEED_OFS) begin
				speed_q <= pwdata[7:0];
			end
		end
	end

	// ---------------- position sensing ----------------
	bss_sync #(
		.WIDTH(3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({rotation_sense, hall_negative_input, hall_positive_input}),
		.sync_out(sync_s)
	);

	// equal levels keep the last state, which gives the comparator its hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hall_q <= 1'b0;
		end else if (sync_s[0] != sync_s[1]) begin
			hall_q <= sync_s[0];
		end
	end

	bss_period_meter #(
		.CNT_W(TW)
	) u_meter (
		.pclk       (pclk),
		.presetn    (presetn),
		.level_in   (hall_q),
		.rise_pulse (hall_rise),
		.edge_pulse (hall_edge),
		.period     (period),
		.live_period(live_period)
	);

	// ---------------- setting decode ----------------
	assign fst_code = setup_q[`BSS_SETUP_FST_LSB +: 8];
	always_comb begin
		if (fst_code >= `BSS_FST_STEP2_MIN) begin
			fst_step = 2'h2;
		end else if (fst_code >= `BSS_FST_STEP1_MIN) begin
			fst_step = 2'h1;
		end else begin
			fst_step = 2'h0;
		end
	end

	// rate step picks the forced commutation step time
	always_comb begin
		case (fst_step_q)
			2'h2:    fst_t = TW'(FST2_CYC);
			2'h1:    fst_t = TW'(FST1_CYC);
			default: fst_t = TW'(FST0_CYC);
		endcase
	end

	// direction and rate step are frozen at start so a mid-start write cannot skew them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q       <= 1'b0;
			fst_step_q  <= 2'h0;
			after_exc_q <= 1'b0;
		end else if (state_q == bss_pkg::bss_st_idle && state_d == bss_pkg::bss_st_detect) begin
			dir_q       <= dir_sel_q;
			fst_step_q  <= fst_step;
			after_exc_q <= 1'b0;
		end else if (state_q == bss_pkg::bss_st_pwm && state_d == bss_pkg::bss_st_rbrake) begin
			dir_q       <= dir_sel_q;
			after_exc_q <= 1'b1; // reversal in drive brakes, then re-runs excitation and forced commutation
		end
	end

	// ---------------- sequencer ----------------
	assign in_exc    = (state_q == bss_pkg::bss_st_exc1) || (state_q == bss_pkg::bss_st_exc2);
	assign unit_tick = in_exc && (timer_q == EXC_UNIT_T - 1'b1);
	assign fc_tick   = (state_q == bss_pkg::bss_st_forced) && (timer_q == fst_t - 1'b1);
	assign pwm_tick  = (state_q == bss_pkg::bss_st_pwm) && (sub_q < 2'h2) && (timer_q >= period / 6);
	assign det_done  = (state_q == bss_pkg::bss_st_detect) && (timer_q == DETECT_T - 1'b1);
	assign det_ok    = (det_edges_q == 2'h2) && !det_mis_q;

	always_comb begin
		state_d = state_q;
		if (state_q != bss_pkg::bss_st_idle && speed_q == 8'h00) begin
			state_d = bss_pkg::bss_st_idle;
		end else begin
			case (state_q)
				bss_pkg::bss_st_idle: begin
					if (speed_q != 8'h00) state_d = bss_pkg::bss_st_detect;
				end
				bss_pkg::bss_st_detect: begin
					if (det_done) begin
						if (det_ok && det_dir_q == dir_q) begin
							state_d = bss_pkg::bss_st_pwm;
						end else if (det_ok) begin
							state_d = bss_pkg::bss_st_rbrake;
						end else if (live_period >= P40_T) begin
							state_d = bss_pkg::bss_st_exc1;
						end else if (live_period >= P200_T) begin
							state_d = bss_pkg::bss_st_sbrake;
						end
					end
				end
				bss_pkg::bss_st_rbrake: begin
					if (live_period >= P40_T) begin
						state_d = after_exc_q ? bss_pkg::bss_st_exc1 : bss_pkg::bss_st_forced;
					end
				end
				bss_pkg::bss_st_sbrake: begin
					if (live_period >= P40_T) state_d = bss_pkg::bss_st_exc1;
				end
				bss_pkg::bss_st_exc1: begin
					if (unit_tick && units_q == UNITS_LAST) state_d = bss_pkg::bss_st_exc2;
				end
				bss_pkg::bss_st_exc2: begin
					if (unit_tick && units_q == UNITS_LAST) state_d = bss_pkg::bss_st_forced;
				end
				bss_pkg::bss_st_forced: begin
					if (live_period < fst_t) state_d = bss_pkg::bss_st_pwm;
				end
				bss_pkg::bss_st_pwm: begin
					if (dir_sel_q != dir_q) state_d = bss_pkg::bss_st_rbrake;
				end
				default: state_d = bss_pkg::bss_st_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= bss_pkg::bss_st_idle;
		end else begin
			state_q <= state_d;
		end
	end

	// shared timer: detection window, excitation unit, commutation step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_q <= '0;
			units_q <= 6'h00;
		end else if (state_d != state_q || det_done) begin
			timer_q <= '0;
			units_q <= 6'h00;
		end else if (unit_tick) begin
			timer_q <= '0;
			units_q <= units_q + 6'h01;
		end else if (fc_tick || pwm_tick || (state_q == bss_pkg::bss_st_pwm && hall_edge)) begin
			timer_q <= '0;
		end else if (state_q == bss_pkg::bss_st_detect || in_exc || state_q == bss_pkg::bss_st_forced ||
			     state_q == bss_pkg::bss_st_pwm) begin
			timer_q <= timer_q + 1'b1;
		end
	end

	// direction detection: two rising edges with a consistent sense level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_edges_q <= 2'h0;
			det_mis_q   <= 1'b0;
			det_dir_q   <= 1'b0;
		end else if (state_q != bss_pkg::bss_st_detect || det_done) begin
			det_edges_q <= 2'h0;
			det_mis_q   <= 1'b0;
		end else if (hall_rise) begin
			det_dir_q <= sync_s[2];
			if (det_edges_q != 2'h0 && sync_s[2] != det_dir_q) det_mis_q <= 1'b1;
			if (det_edges_q != 2'h2) det_edges_q <= det_edges_q + 2'h1;
		end
	end

	// commutation step; without interpolation from a single sensor only thirds of a half period are used
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_q <= 3'h0;
			sub_q  <= 2'h0;
		end else if (state_q == bss_pkg::bss_st_pwm && hall_edge) begin
			step_q <= hall_q ? 3'h0 : 3'h3;
			sub_q  <= 2'h0;
		end else if (fc_tick || pwm_tick) begin
			sub_q <= sub_q + 2'h1;
			if (!dir_q) begin
				step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
			end else begin
				step_q <= (step_q == 3'h0) ? 3'h5 : step_q - 3'h1;
			end
		end
	end

	// ---------------- output stage ----------------
	assign duty   = (state_q == bss_pkg::bss_st_pwm) ? speed_q : setup_q[`BSS_SETUP_VST_LSB +: 8];
	assign pwm_on = pwm_cnt_q < duty;

	// free-running carrier, about 488 kHz at 125 MHz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_cnt_q <= 8'h00;
		end else begin
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
		end
	end

	// excitation pattern, key is {direction, hall, stage two}
	function automatic bss_pkg::bss_phase_t exc_ph(input logic [2:0] key, input int ph);
		bss_pkg::bss_phase_t u;
		bss_pkg::bss_phase_t v;
		bss_pkg::bss_phase_t w;
		u = bss_pkg::bss_ph_off;
		v = bss_pkg::bss_ph_off;
		w = bss_pkg::bss_ph_off;
		case (key)
			3'b010:  begin u = bss_pkg::bss_ph_lo_full; w = bss_pkg::bss_ph_hi_pwm;  end
			3'b011:  begin v = bss_pkg::bss_ph_lo_pwm;  w = bss_pkg::bss_ph_hi_full; end
			3'b000:  begin u = bss_pkg::bss_ph_hi_full; w = bss_pkg::bss_ph_lo_pwm;  end
			3'b001:  begin v = bss_pkg::bss_ph_hi_pwm;  w = bss_pkg::bss_ph_lo_full; end
			3'b110:  begin u = bss_pkg::bss_ph_hi_pwm;  w = bss_pkg::bss_ph_lo_full; end
			3'b111:  begin u = bss_pkg::bss_ph_hi_full; v = bss_pkg::bss_ph_lo_pwm;  end
			3'b100:  begin u = bss_pkg::bss_ph_lo_pwm;  w = bss_pkg::bss_ph_hi_full; end
			default: begin u = bss_pkg::bss_ph_lo_full; v = bss_pkg::bss_ph_hi_pwm;  end
		endcase
		return (ph == 0) ? u : ((ph == 1) ? v : w);
	endfunction : exc_ph

	// six-step table: high-side pwm on phase step/2, low side full on the next phase in even steps and the one after it in odd steps
	function automatic bss_pkg::bss_phase_t six_ph(input logic [2:0] step, input int ph);
		int hi;
		int lo;
		hi = int'(step) / 2;
		lo = ((int'(step) + 1) / 2 + 1) % 3;
		if (ph == hi) return bss_pkg::bss_ph_hi_pwm;
		if (ph == lo) return bss_pkg::bss_ph_lo_full;
		return bss_pkg::bss_ph_off;
	endfunction : six_ph

	for (genvar p = 0; p < 3; p++) begin : g_phase
		bss_pkg::bss_phase_t ph;

		always_comb begin
			case (state_q)
				bss_pkg::bss_st_sbrake: ph = bss_pkg::bss_ph_lo_full;
				bss_pkg::bss_st_rbrake: ph = six_ph(hall_q ? 3'h0 : 3'h3, p);
				bss_pkg::bss_st_exc1:   ph = exc_ph({dir_q, hall_q, 1'b0}, p);
				bss_pkg::bss_st_exc2:   ph = exc_ph({dir_q, hall_q, 1'b1}, p);
				bss_pkg::bss_st_forced: ph = six_ph(step_q, p);
				bss_pkg::bss_st_pwm:    ph = six_ph(step_q, p);
				default:                ph = bss_pkg::bss_ph_off;
			endcase
		end

		// gates are registered; the two sides of one phase never come on together
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				phase_high_q[p] <= 1'b0;
				phase_low_q[p]  <= 1'b0;
			end else begin
				phase_high_q[p] <= (ph == bss_pkg::bss_ph_hi_full) || (ph == bss_pkg::bss_ph_hi_pwm && pwm_on);
				phase_low_q[p]  <= (ph == bss_pkg::bss_ph_lo_full) || (ph == bss_pkg::bss_ph_lo_pwm && pwm_on);
			end
		end
	end

endmodule : bss_startup_seq

`default_nettype wire

// File: tb/bss_startup_seq_assertions.sv
/* port checker for the startup sequencer: apb handshake and gate outputs
 * assumes binding onto bss_startup_seq, one clock domain */
`timescale 1ns/100ps
`default_nettype none
module bss_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        hall_positive_input,
	input wire logic        hall_negative_input,
	input wire logic        rotation_sense,
	input wire logic [2:0]  phase_high_q,
	input wire logic [2:0]  phase_low_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb answers with zero wait states, one cycle at a time
	a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
	a_err_decode: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C,
		12'h010})) else $error("slave error wrong for address");
	a_err_alone: assert property (pslverr |-> pready) else $error("slave error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
	// gates: never shoot-through, one high side at most, dark after stop or reset
	a_no_shoot: assert property ((phase_high_q & phase_low_q) == 3'h0) else $error("shoot-through");
	a_one_high: assert property ($onehot0(phase_high_q)) else $error("two high sides on");
	a_stop_dark: assert property (pready && pwrite && paddr == 12'h008 && pwdata[7:0] == 8'h00
		|-> ##[1:3] (phase_high_q | phase_low_q) == 3'h0) else $error("gates on after stop");
	a_reset_dark: assert property ($rose(presetn) |-> (phase_high_q | phase_low_q) == 3'h0)
		else $error("gates on after reset");
	cover property (pready && pslverr);
	cover property (pready && pwrite);
	cover property (phase_low_q == 3'h7);
endmodule : bss_sva
bind bss_startup_seq bss_sva u_sva (.*);
`default_nettype wire

// File: tb/bss_motor.sv
/* behavioural single-hall motor with a direction sense pin
 * assumes the bench clock; half_cyc 0 makes the rotor stand at rest_lvl */
`timescale 1ns/100ps
`default_nettype none
module bss_motor (
	input  wire logic        pclk,
	input  wire logic [31:0] half_cyc,
	input  wire logic        rev,
	input  wire logic        garble,
	input  wire logic        rest_lvl,
	output logic             hall_positive_input,
	output logic             hall_negative_input,
	output logic             rotation_sense
);
	int   cnt = 0;
	logic h   = 1'b0;
	logic s   = 1'b0;
	// rotor turns at the asked half period; garbled sense flips on each rise
	always @(posedge pclk) begin
		if (half_cyc == 0) begin
			h <= rest_lvl;
			cnt <= 0;
		end else if (cnt >= half_cyc - 1) begin
			cnt <= 0;
			h <= !h;
			if (!h) s <= garble ? !s : rev;
		end else cnt <= cnt + 1;
	end
	// comparator pair kept opposite so hall state is never ambiguous
	assign hall_positive_input = h;
	assign hall_negative_input = !h;
	assign rotation_sense      = s;
endmodule : bss_motor
`default_nettype wire

// File: tb/tb.sv
/* self-checking bench for the startup sequencer
 * assumes the motor model on the pins and apb stimulus from here */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hp;
	logic        hn;
	logic        sense;
	logic [2:0]  ph_hi;
	logic [2:0]  ph_lo;
	int          half = 0;
	logic        rev = 1'b0;
	logic        garble = 1'b0;
	logic        rest = 1'b0;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          seed = 69615;
	int          el;
	logic [2:0]  cur;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  code[3] = '{8'h28, 8'h78, 8'h00};
	int          stp[3] = '{1, 2, 0};
	int          forced_commutation_rate_setting[3] = '{0, 0, 150}; // 0: full-length step time, far beyond the run
	// rate steps 2 and 1 keep their full-length step times; only step 0 is shortened
	bss_startup_seq #(.EXC_UNIT_CYC(20), .DETECT_CYC(200), .P40_CYC(400), .P200_CYC(80),
		.FST0_CYC(150)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hall_positive_input(hp), .hall_negative_input(hn), .rotation_sense(sense),
		.phase_high_q(ph_hi), .phase_low_q(ph_lo));
	bss_motor u_motor (.pclk(pclk), .half_cyc(half), .rev(rev), .garble(garble), .rest_lvl(rest),
		.hall_positive_input(hp), .hall_negative_input(hn), .rotation_sense(sense));
	// free-running clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		chk(pready, 1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// poll state until exp appears; any other new state ends the wait early
	task automatic wait_st(input logic [2:0] exp);
		el = 0;
		do begin
			apb(1'b0, 12'h00C, 32'h0);
			el += 3;
		end while (rd[2:0] !== exp && rd[2:0] === cur && el < 9000);
		chk(rd[2:0], exp);
		cur = rd[2:0];
	endtask : wait_st
	// motor settles first so old periods do not leak into detection
	task automatic go(input int hc, input logic [7:0] c);
		half <= hc;
		repeat (800) @(posedge pclk);
		apb(1'b1, 12'h004, {16'h0, 8'($random(seed)), c});
		apb(1'b1, 12'h008, 32'($random(seed)) | 32'h1);
		cur = 3'h0;
	endtask : go
	task automatic halt;
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd[2:0], 0);
	endtask : halt
	// mid-run reset brings back the all-ones period, so a full-length rate step holds forced commutation
	task automatic pulse_reset;
		half <= 0;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({ph_hi, ph_lo}, 6'h00);
	endtask : pulse_reset
	task automatic wrap_up;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// watchdog well beyond the expected run
	initial begin
		#(8 * 90000);
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h07FFFFFF);
		apb(1'b1, 12'h014, 32'hFFFFFFFF);
		chk(err, 1);
		apb(1'b0, 12'h014, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		// stationary rotor: excitation then forced, one pass per rate step
		for (int i = 0; i < 3; i++) begin
			rest <= i[0];
			if (i < 2) pulse_reset;
			go(0, code[i]);
			wait_st(3'h1);
			chk(rd[6:5], stp[i]);
			wait_st(3'h4);
			if (i[0]) chk({ph_hi[1:0], ph_lo}, 5'b00001);
			else chk({ph_hi, ph_lo[1:0]}, 5'b00100);
			wait_st(3'h5);
			chk(el >= 636 && el <= 644, 1);
			if (i[0]) chk({ph_hi, ph_lo[2], ph_lo[0]}, 5'b10000);
			else chk({ph_hi[2], ph_hi[0], ph_lo}, 5'b00100);
			wait_st(3'h6);
			chk(el >= 636 && el <= 644, 1);
			half <= (forced_commutation_rate_setting[i] == 0) ? 0 : (forced_commutation_rate_setting[i] + 20) / 2;
			repeat (1000) @(posedge pclk);
			apb(1'b0, 12'h00C, 32'h0);
			chk(rd[2:0], 6);
			half <= (forced_commutation_rate_setting[i] == 0) ? 20 : (forced_commutation_rate_setting[i] - 10) / 2;
			wait_st(3'h7);
			halt;
		end
		// spinning rotor in the selected direction, both directions
		for (int d = 0; d < 2; d++) begin
			rev <= d[0];
			apb(1'b1, 12'h000, 32'(d));
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, d);
			go(20, 8'h00);
			wait_st(3'h1);
			wait_st(3'h7);
			halt;
		end
		rev <= 1'b0;
		go(20, 8'h00);
		wait_st(3'h1);
		wait_st(3'h2);
		half <= 0;
		wait_st(3'h6);
		halt;
		go(150, 8'h00);
		wait_st(3'h1);
		wait_st(3'h3);
		chk({ph_hi, ph_lo}, 6'h07);
		half <= 0;
		wait_st(3'h4);
		halt;
		garble <= 1'b1;
		go(20, 8'h00);
		repeat (1000) @(posedge pclk);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd[2:0], 1);
		halt;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
